// ===== qsd_pkg.sv
// Constants for the quad supply serial command decoder
package qsd_pkg;
  localparam int WORD_BITS = 16;
  localparam int DEV_ID_W = 4;
  // Device select value; arbitrary value
  localparam logic [3:0] DEV_ID_DEFAULT = 4'h5;
  localparam int BIT_RW = 15;
  localparam int BIT_BANK = 14;
  localparam int BIT_CH_HI = 13;
  localparam int BIT_CH_LO = 12;
  localparam int BIT_CLK_INIT = 0;
  localparam int BIT_GLOBAL = 2;
  localparam int BIT_OFF = 3;
  localparam int BIT_INIT_QUAL = 5;
  localparam logic [7:0] INIT_DATA = 8'h09;
  localparam logic [3:0] CODE_PASS = 4'hf;
  // DAC steps are 200 mV; a code step of 400 mV is two DAC steps
  localparam logic [5:0] DAC_PASS = 6'h1f;
  localparam int STAGGER_CYCLES = 4;
  // DAC step period in link clocks: 87 us at 4.416 MHz
  localparam int STEP_LINK_CLKS = 384;
  // Ready filter: 250 us at 4.416 MHz link clock
  localparam int FILT_US = 250;
  localparam int LINK_KHZ = 4416;
  localparam int FILT_LINK_CLKS = FILT_US * LINK_KHZ / 1000;
  localparam int PWM_DIV = 8;
  localparam logic [7:0] ST_READY = 8'h00;
  localparam logic [7:0] ST_OFF = 8'h01;
  localparam logic [7:0] ST_DUTY = 8'h02;
  localparam logic [7:0] ST_OVC = 8'h04;
  localparam logic [7:0] ST_MOVE = 8'h08;
  localparam logic [7:0] ST_TEMP = 8'h10;
endpackage

// ===== qsd_decoder.sv
// Serial command decoder and status responder for a four channel supply
////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Sample frame sync and serial data on each falling link clock edge.
// - Frame sync high holds bit and frame counters in reset.
// - Words are 16 bits, MSB first, bit 15 on first falling edge.
// - Upper byte is command/address, lower byte is data.
// - Accept a word only if bank bit equals bank select pin; the init word is accepted on either bank.
// - Two channel select bits pick one of four channels.
// - Respond only when device select field equals assigned ID.
// - Data 09h with zero address bits initialises clocks, disables all.
// - Clock init bit works only when ANDed with inverted data bit 5.
// - Data vvvv0100 programs and starts all four channels together.
// - Data vvvv0000 enables addressed channel at code vvvv.
// - Code 0 is 7.5 V, +0.4 V per code, F is pass-through.
// - Pass-through holds the channel switch fully on.
// - Read word returns addressed channel status byte.
// - Status 00h only when settled in regulation, else non-zero.
// - Not ready if off, duty 0/100%, overcurrent, moving; temp all.
// - Status leaves through an open-drain data output.
// - Ready indication may lag stable output by up to 250 us.
// - Word bit 15 high is a read, low is a write.
// - Low bank device starts PWM ramp four link clocks later.
// - DAC steps toward target by 200 mV about every 87 us.
module qsd_decoder #(
  parameter logic [3:0] DEV_ID = qsd_pkg::DEV_ID_DEFAULT,
  parameter int STEP_CLKS = qsd_pkg::STEP_LINK_CLKS,
  parameter int FILT_CLKS = qsd_pkg::FILT_LINK_CLKS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic frame_sync_in,
  input wire logic serial_in,
  input wire logic bank_select_pin,
  input wire logic [3:0] overcurrent,
  input wire logic [3:0] duty_extreme,
  input wire logic over_temp,
  output logic serial_out_open_drain_o,
  output logic serial_out_open_drain_oe,
  output logic [3:0] ch_enable,
  output logic [3:0] ch_pass_through,
  output logic [23:0] ch_dac,
  output logic pwm_ramp_start
);
  typedef enum logic [2:0] {
    QSD_IDLE = 3'b001,
    QSD_SHIFT = 3'b010,
    QSD_DONE = 3'b100
  } qsd_state_t;

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling: three flops, change counted when second and third agree
  logic [2:0] clk_s_r, fs_s_r, sd_s_r, bk_s_r;
  logic lclk_r, fs_r, sd_r;
  always_ff @(posedge mclk) begin
    clk_s_r <= {clk_s_r[1:0], link_clk};
    fs_s_r <= {fs_s_r[1:0], frame_sync_in};
    sd_s_r <= {sd_s_r[1:0], serial_in};
    // The bank strap is a pin as well, so it crosses domains the same way
    bk_s_r <= {bk_s_r[1:0], bank_select_pin};
  end
  wire clk_agree = clk_s_r[1] == clk_s_r[2];
  wire clk_lvl = clk_agree ? clk_s_r[2] : lclk_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      lclk_r <= 1'b0;
      fs_r <= 1'b0;
      sd_r <= 1'b0;
    end else begin
      lclk_r <= clk_lvl;
      if (fs_s_r[1] == fs_s_r[2]) fs_r <= fs_s_r[2];
      if (sd_s_r[1] == sd_s_r[2]) sd_r <= sd_s_r[2];
    end
  end
  wire fall = lclk_r & ~clk_lvl;
  wire rise = ~lclk_r & clk_lvl;

  ////////////////////////////////////////////////////////////////////////
  // Word receive
  qsd_state_t st_r, st_nxt;
  logic [4:0] bitcnt_r;
  logic [15:0] shreg_r;
  logic word_r;
  logic bank_r;
  wire [15:0] shifted = {shreg_r[14:0], sd_r};
  wire last_bit = bitcnt_r == 5'(qsd_pkg::WORD_BITS - 1);
  always_comb begin
    case (st_r)
      QSD_IDLE: st_nxt = (fall && fs_r) ? QSD_SHIFT : QSD_IDLE;
      QSD_SHIFT: st_nxt = (fall && !fs_r && last_bit) ? QSD_DONE : QSD_SHIFT;
      QSD_DONE: st_nxt = (fall && fs_r) ? QSD_SHIFT : QSD_DONE;
      default: st_nxt = QSD_IDLE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= QSD_IDLE;
      bitcnt_r <= 5'h00;
      shreg_r <= 16'h0000;
      word_r <= 1'b0;
      bank_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (bk_s_r[1] == bk_s_r[2]) bank_r <= bk_s_r[2];
      word_r <= 1'b0;
      if (fall) begin
        if (fs_r) begin
          bitcnt_r <= 5'h00;
        end else if (st_r == QSD_SHIFT) begin
          shreg_r <= shifted;
          bitcnt_r <= bitcnt_r + 5'h01;
          word_r <= last_bit;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field decode
  wire [7:0] dat = shreg_r[7:0];
  wire is_read = shreg_r[qsd_pkg::BIT_RW];
  wire bank_ok = shreg_r[qsd_pkg::BIT_BANK] == bank_r;
  wire id_ok = shreg_r[11:8] == DEV_ID;
  wire [1:0] ch = {shreg_r[qsd_pkg::BIT_CH_HI], shreg_r[qsd_pkg::BIT_CH_LO]};
  wire [3:0] ch_dec = 4'h1 << ch;
  wire [3:0] vcode = dat[7:4];
  wire for_us = word_r && id_ok;
  // The only init pattern carries bit 5 low, so the AND gate must see it
  wire init_pat = for_us && !is_read && shreg_r[14:12] == 3'h0 &&
    dat == qsd_pkg::INIT_DATA;
  wire init_gate = dat[qsd_pkg::BIT_CLK_INIT] &
    ~dat[qsd_pkg::BIT_INIT_QUAL];
  wire w_init = init_pat & init_gate;
  wire w_ok = for_us && !is_read && bank_ok;
  wire w_glob = w_ok && dat[3:0] == 4'h4;
  wire w_on = w_ok && dat[3:0] == 4'h0;
  wire w_off = w_ok && dat[qsd_pkg::BIT_OFF] && !w_init;
  function automatic logic [5:0] code_to_dac(input logic [3:0] c);
    // 200 mV DAC steps: 7.5 V sits 37.5 steps up, so code counts from 0
    code_to_dac = (c == qsd_pkg::CODE_PASS) ? qsd_pkg::DAC_PASS :
      {1'b0, c, 1'b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Channel state, DAC stepping, ready filter
  logic [3:0] en_r;
  logic [5:0] tgt_r [4];
  logic [5:0] dac_r [4];
  logic [8:0] step_r;
  logic [10:0] filt_r [4];
  logic [7:0] stat_r [4];
  logic [2:0] pwm_r;
  logic [2:0] stag_r;
  logic [3:0] pass_r;
  wire step_tick = fall && step_r == 9'(STEP_CLKS - 1);
  always_ff @(posedge mclk) begin
    if (rst) begin
      en_r <= 4'h0;
      step_r <= 9'h000;
    end else begin
      if (fall) step_r <= step_tick ? 9'h000 : step_r + 9'h001;
      if (w_init) en_r <= 4'h0;
      else if (w_glob) en_r <= 4'hf;
      else if (w_on) en_r <= en_r | ch_dec;
      else if (w_off) en_r <= en_r & ~ch_dec;
    end
  end
  for (genvar i = 0; i < 4; i++) begin : g_ch
    wire [5:0] goal = en_r[i] ? tgt_r[i] : 6'h00;
    wire moving = dac_r[i] != goal;
    wire raw_bad = !en_r[i] || duty_extreme[i] || overcurrent[i] || moving;
    always_ff @(posedge mclk) begin
      if (rst) begin
        tgt_r[i] <= 6'h00;
        dac_r[i] <= 6'h00;
        filt_r[i] <= 11'h000;
        stat_r[i] <= qsd_pkg::ST_OFF;
        pass_r[i] <= 1'b0;
      end else begin
        if (w_init) tgt_r[i] <= 6'h00;
        else if (w_glob || (w_on && ch_dec[i])) tgt_r[i] <= code_to_dac(vcode);
        if (step_tick && moving)
          dac_r[i] <= dac_r[i] < goal ? dac_r[i] + 6'h01 : dac_r[i] - 6'h01;
        pass_r[i] <= en_r[i] && dac_r[i] == qsd_pkg::DAC_PASS;
        if (raw_bad || over_temp) filt_r[i] <= 11'h000;
        else if (fall && filt_r[i] != 11'(FILT_CLKS))
          filt_r[i] <= filt_r[i] + 11'h001;
        stat_r[i] <= (!en_r[i] ? qsd_pkg::ST_OFF : 8'h00) |
          (duty_extreme[i] ? qsd_pkg::ST_DUTY : 8'h00) |
          (overcurrent[i] ? qsd_pkg::ST_OVC : 8'h00) |
          (moving || filt_r[i] != 11'(FILT_CLKS) ? qsd_pkg::ST_MOVE : 8'h00) |
          (over_temp ? qsd_pkg::ST_TEMP : 8'h00);
      end
    end
    assign ch_dac[i*6 +: 6] = dac_r[i];
  end
  assign ch_enable = en_r;
  assign ch_pass_through = pass_r;

  ////////////////////////////////////////////////////////////////////////
  // PWM ramp sync: divide by eight on rising edges, stagger for low bank
  always_ff @(posedge mclk) begin
    if (rst) begin
      pwm_r <= 3'h0;
      stag_r <= 3'h0;
      pwm_ramp_start <= 1'b0;
    end else begin
      pwm_ramp_start <= 1'b0;
      if (w_init) begin
        pwm_r <= 3'h0;
        stag_r <= bank_r ? 3'h0 : 3'(qsd_pkg::STAGGER_CYCLES);
      end else if (rise) begin
        if (stag_r != 3'h0) stag_r <= stag_r - 3'h1;
        else begin
          pwm_r <= pwm_r + 3'h1;
          pwm_ramp_start <= pwm_r == 3'h0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status readback: command byte seen at bit 8, drive on falling edges
  wire hdr_done = fall && !fs_r && st_r == QSD_SHIFT &&
    bitcnt_r == 5'h07;
  // Status is latched at the command byte: a change later in the frame
  // only shows on the next poll
  wire [15:0] hdr = {shifted[7:0], 8'h00};
  wire hdr_rd = hdr[15] && hdr[11:8] == DEV_ID && hdr[14] == bank_r;
  logic [7:0] out_r;
  logic [3:0] outcnt_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_r <= 8'h00;
      outcnt_r <= 4'h0;
      serial_out_open_drain_oe <= 1'b0;
    end else if (fall && fs_r) begin
      outcnt_r <= 4'h0;
      serial_out_open_drain_oe <= 1'b0;
    end else if (hdr_done && hdr_rd) begin
      out_r <= stat_r[{hdr[13], hdr[12]}] << 1;
      outcnt_r <= 4'h8;
      serial_out_open_drain_oe <= !stat_r[{hdr[13], hdr[12]}][7];
    end else if (fall && outcnt_r != 4'h0) begin
      outcnt_r <= outcnt_r - 4'h1;
      out_r <= out_r << 1;
      // Drive low for a zero, release for a one
      serial_out_open_drain_oe <= outcnt_r != 4'h1 && !out_r[7];
    end
  end
  assign serial_out_open_drain_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  busy_release_a: assert property (@(posedge mclk) disable iff (rst)
    (fall && fs_r) |=> !serial_out_open_drain_oe)
    else $error("output not released at frame sync");
  init_clears_a: assert property (@(posedge mclk) disable iff (rst)
    w_init |=> en_r == 4'h0)
    else $error("init did not disable channels");
  global_on_a: assert property (@(posedge mclk) disable iff (rst)
    (w_glob && !w_init) |=> en_r == 4'hf)
    else $error("global on did not enable all");
  ch_off_a: assert property (@(posedge mclk) disable iff (rst)
    (w_off && !w_glob && !w_on) |=> (en_r & $past(ch_dec)) == 4'h0)
    else $error("channel not disabled");
  ch_on_a: assert property (@(posedge mclk) disable iff (rst)
    (w_on && !w_init) |=> (en_r & $past(ch_dec)) == $past(ch_dec))
    else $error("channel not enabled");
  foreign_id_a: assert property (@(posedge mclk) disable iff (rst)
    (word_r && !id_ok) |=> $stable(en_r))
    else $error("foreign word changed state");
  counter_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (fall && fs_r) |=> bitcnt_r == 5'h00)
    else $error("bit counter not held");
  temp_status_a: assert property (@(posedge mclk) disable iff (rst)
    over_temp |=> stat_r[0] != 8'h00 && stat_r[3] != 8'h00)
    else $error("over temperature not reported");
  bank_gate_a: assert property (@(posedge mclk) disable iff (rst)
    (word_r && shreg_r[14] != bank_r && shreg_r[14:12] != 3'h0)
    |=> $stable(en_r))
    else $error("wrong bank accepted");
  unlisted_cmd_a: assert property (@(posedge mclk) disable iff (rst)
    (w_ok && !dat[3] && dat[2:0] != 3'h4 && dat[2:0] != 3'h0)
    |=> $stable(en_r))
    else $error("unlisted write changed enables");
  read_inert_a: assert property (@(posedge mclk) disable iff (rst)
    (word_r && is_read) |=> $stable(en_r))
    else $error("read word changed enables");
  pass_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (en_r[1] && dac_r[1] == qsd_pkg::DAC_PASS) |=> ch_pass_through[1])
    else $error("pass-through switch not held on");
  step_only_a: assert property (@(posedge mclk) disable iff (rst)
    !step_tick |=> $stable(ch_dac))
    else $error("DAC moved off a step tick");
  // The stagger only matters for the low bank device of a pair
  stagger_load_a: assert property (@(posedge mclk) disable iff (rst)
    (w_init && !bank_r) |=> stag_r == 3'(qsd_pkg::STAGGER_CYCLES))
    else $error("stagger not loaded");
endmodule

// ===== qsd_master.sv
// Serial bus master model that sends framed 16-bit words
module qsd_master (
  input wire logic mclk,
  input wire logic oe,
  output logic link_clk,
  output logic frame_sync_in,
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Link clock stands still low between frames
  initial begin
    link_clk = 1'b0;
    frame_sync_in = 1'b0;
    serial_in = 1'b0;
  end

  // Half of a 160 ns link period
  task automatic half();
    repeat (16) @(posedge mclk);
  endtask

  task automatic xfer(input logic [15:0] w, output logic [7:0] st);
    st = 8'h00;
    frame_sync_in <= 1'b1;
    half();
    link_clk <= 1'b1;
    half();
    link_clk <= 1'b0;
    half();
    frame_sync_in <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_in <= w[i];
      half();
      link_clk <= 1'b1;
      half();
      // Pin has a pull-up: driving low reads as a zero bit
      if (i < 8) st[i] = ~oe;
      link_clk <= 1'b0;
    end
    half();
    // Data line no longer meaningful; flip it so stale bits never match
    serial_in <= ~serial_in;
  endtask
endmodule

// ===== tb.sv
// Self-checking bench for the quad supply serial command decoder
module tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

  localparam logic [3:0] ID = qsd_pkg::DEV_ID_DEFAULT;
  logic mclk, rst, link_clk, frame_sync_in, serial_in, bank_select_pin;
  logic over_temp, oe_o, oe, pwm_ramp_start;
  logic [3:0] overcurrent, duty_extreme, ch_enable, ch_pass_through;
  logic [23:0] ch_dac;
  logic [7:0] st;
  int error_cnt = 0;
  int n_compared = 0;
  int pulses = 0;

  qsd_decoder #(.STEP_CLKS(4), .FILT_CLKS(8)) u_dut (.mclk(mclk), .rst(rst),
    .link_clk(link_clk), .frame_sync_in(frame_sync_in),
    .serial_in(serial_in), .bank_select_pin(bank_select_pin),
    .overcurrent(overcurrent), .duty_extreme(duty_extreme),
    .over_temp(over_temp), .serial_out_open_drain_o(oe_o),
    .serial_out_open_drain_oe(oe), .ch_enable(ch_enable),
    .ch_pass_through(ch_pass_through), .ch_dac(ch_dac),
    .pwm_ramp_start(pwm_ramp_start));
  qsd_master u_mst (.mclk(mclk), .oe(oe), .link_clk(link_clk),
    .frame_sync_in(frame_sync_in), .serial_in(serial_in));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) if (pwm_ramp_start) pulses++;

  function automatic logic [15:0] wd(logic rw, logic bank, logic [1:0] ch,
                                     logic [7:0] d);
    return {rw, bank, ch, ID, d};
  endfunction
  // Writes wait past the two-cycle apply latency before anyone looks
  task automatic wr(input logic bank, input logic [1:0] ch,
                    input logic [7:0] d);
    u_mst.xfer(wd(1'b0, bank, ch, d), st);
    repeat (10) @(posedge mclk);
  endtask
  // Data bit 3 set on purpose: a read must never act as a disable
  task automatic rd(input logic [1:0] ch);
    u_mst.xfer(wd(1'b1, 1'b1, ch, 8'h08), st);
  endtask
  // Polls back to back; link edges only run inside frames
  // Each poll spans 17 link clocks, longer than the shortened filter
  task automatic settle(input logic [1:0] ch);
    rd(ch);
    for (int k = 0; k < 10; k++) begin
      if (st !== 8'h00) rd(ch);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    // About twice the expected length of the whole run
    repeat (90000) @(posedge mclk);
    error_cnt++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    bank_select_pin = 1'b1;
    over_temp = 1'b0;
    overcurrent = 4'h0;
    duty_extreme = 4'h0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK(ch_enable, 4'h0)
    `CHK(ch_dac, 24'h000000)
    `CHK(oe, 1'b0)
    `CHK(oe_o, 1'b0)
    $display("reset test done");
    for (int c = 0; c < 16; c++) begin
      wr(1'b1, 2'd1, {c[3:0], 4'h0});
      `CHK(ch_enable, 4'h2)
      settle(2'd1);
      `CHK(ch_dac[11:6], (c == 15) ? qsd_pkg::DAC_PASS : {1'b0, c[3:0], 1'b0})
      `CHK(ch_pass_through[1], c == 15)
      if (c < 15) `CHK(st, qsd_pkg::ST_READY)
    end
    $display("code test done");
    u_mst.xfer({4'b0101, ~ID, 8'h30}, st);
    wr(1'b0, 2'd1, 8'h30);
    wr(1'b1, 2'd1, 8'h02);
    `CHK(ch_enable, 4'h2)
    `CHK(ch_dac[11:6], qsd_pkg::DAC_PASS)
    wr(1'b1, 2'd1, 8'hf8);
    `CHK(ch_enable, 4'h0)
    rd(2'd1);
    `CHK(st & qsd_pkg::ST_OFF, qsd_pkg::ST_OFF)
    `CHK(oe, 1'b0)
    $display("refuse and disable test done");
    wr(1'b1, 2'd2, 8'h34);
    `CHK(ch_enable, 4'hf)
    rd(2'd3);
    `CHK(st != 8'h00, 1'b1)
    settle(2'd3);
    // Channel 1 is still stepping down from pass-through
    settle(2'd1);
    `CHK(ch_dac, {4{6'h06}})
    for (int f = 0; f < 3; f++) begin
      @(posedge mclk);
      over_temp <= (f == 0);
      duty_extreme <= {f == 1, 3'b000};
      overcurrent <= {f == 2, 3'b000};
      rd((f == 0) ? 2'd0 : 2'd3);
      `CHK(st != 8'h00, 1'b1)
      over_temp <= 1'b0;
      duty_extreme <= 4'h0;
      overcurrent <= 4'h0;
      settle(2'd3);
      `CHK(st, qsd_pkg::ST_READY)
    end
    $display("global and fault test done");
    wr(1'b1, 2'd3, 8'h29);
    `CHK(ch_enable, 4'h7)
    wr(1'b0, 2'd0, qsd_pkg::INIT_DATA);
    `CHK(ch_enable, 4'h0)
    // High bank: ramp starts on rising link edges 1, 9 and 17 of a frame
    pulses = 0;
    rd(2'd0);
    `CHK(pulses, 3)
    // Low bank: four edges later, so only edges 5 and 13 start a ramp
    bank_select_pin <= 1'b0;
    wr(1'b0, 2'd0, qsd_pkg::INIT_DATA);
    pulses = 0;
    rd(2'd0);
    `CHK(pulses, 2)
    $display("init test done");
    end_of_test();
  end
endmodule
